// [rtl/sse_exec.sv]
// Functional notes
// - The halt instruction clears the power-down flag and sets the time-out flag.
// - The halt instruction zeroes the watchdog counter and its prescaler.
// - After halt the core sleeps with its main oscillator stopped.
// - Subtract-from-file gives file operand minus W, file addressed by a 7-bit field.
// - For subtract-from-file, destination 0 writes W and destination 1 writes the file.
// - Subtract-with-borrow gives file minus W minus the inverted carry.
// - For subtract-with-borrow, destination 0 writes W and destination 1 the file.
// - Subtract-from-literal gives the 8-bit immediate minus W, always into W.
// - The nibble exchange swaps the two halves of the file operand, flags untouched.
// - For the nibble exchange, destination 0 writes W and destination 1 the file.
// - Direction-load copies W to direction A, B or C for selector 5, 6 or 7, no flags.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "sse_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sse_exec (
    // Clock, reset and enable
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic                         clockEnable,
    // Decoded instruction
    input  wire logic                         execValid,
    input  wire sse_pkg::sse_op_type          opcode,
    input  wire logic [6:0]                   fileAddr,
    input  wire logic                         destSel,
    input  wire logic [7:0]                   literal,
    input  wire logic [7:0]                   fileData,
    output logic                              execReady,
    // File register write-back
    output logic                              fileWriteStrobe,
    output logic [6:0]                        fileWriteAddr,
    output logic [7:0]                        fileWriteData,
    // Power control
    input  wire logic                         wakeRequest,
    output logic                              sleepState,
    output logic                              oscillatorRun,
    output logic                              timeoutStatusFlag,
    output logic                              powerdownStatusFlag,
    // Core visible state
    output logic [7:0]                        workReg,
    output logic                              carryFlag,
    output logic                              halfCarryFlag,
    output logic                              zeroFlag,
    output logic [7:0]                        watchdogCounter,
    output logic [7:0]                        portADirection,
    output logic [7:0]                        portBDirection,
    output logic [7:0]                        portCDirection,
    // Register port
    input  wire logic [`SSE_ADDR_WIDTH-1:0]   regAddr,
    input  wire logic [7:0]                   regWriteData,
    input  wire logic                         regWrite,
    input  wire logic                         regRead,
    output logic [7:0]                        regReadData
);

    // ****************************************
    // State and reset value
    // ****************************************
    localparam sse_pkg::sse_state_type RESET_STATE = '{
        workReg:       `SSE_WORK_RESET,
        carry:         1'b0,
        halfCarry:     1'b0,
        zero:          1'b0,
        powerdownFlag: 1'b1,
        timeoutFlag:   1'b1,
        power:         sse_pkg::SSE_RUN,
        watchdog:      `SSE_WATCHDOG_CLEAR,
        prescale:      `SSE_PRESCALE_CLEAR,
        dirA:          `SSE_DIR_RESET,
        dirB:          `SSE_DIR_RESET,
        dirC:          `SSE_DIR_RESET,
        fileWrite:     1'b0,
        fileWrAddr:    7'h00,
        fileWrData:    8'h00,
        readData:      8'h00
    };

    sse_pkg::sse_state_type state;
    sse_pkg::sse_state_type next_state;

    // ****************************************
    // Arithmetic datapath
    // ****************************************
    logic       isLiteral;
    logic       isBorrow;
    logic [7:0] minuend;
    logic       carryIn;
    logic [8:0] subSum;
    logic [4:0] nibSum;
    logic [7:0] subResult;
    logic [7:0] swapped;
    logic       accepted;

    // Operand and borrow-in selection
    assign isLiteral = (opcode == sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP);
    assign isBorrow  = (opcode == sse_pkg::SSE_SUBTRACT_WITH_BORROW_OP);
    assign minuend   = isLiteral ? literal : fileData;
    assign carryIn   = isBorrow ? state.carry : 1'b1;

    // Subtract as add of inverted W plus carry-in
    assign subSum    = {1'b0, minuend} + {1'b0, ~state.workReg} + {8'h00, carryIn};
    assign nibSum    = {1'b0, minuend[3:0]} + {1'b0, ~state.workReg[3:0]}
                       + {4'h0, carryIn};
    assign subResult = subSum[7:0];
    assign swapped   = {fileData[3:0], fileData[7:4]};

    // Instructions are only taken while awake
    assign accepted  = execValid && (state.power == sse_pkg::SSE_RUN);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_state           = state;
        next_state.fileWrite = 1'b0;
        next_state.readData  = 8'h00;

        // Watchdog prescaler runs in both power states
        next_state.prescale = state.prescale + 8'h01;
        if (&state.prescale) begin
            next_state.watchdog = state.watchdog + 8'h01;
        end

        // Register read, answered next cycle
        if (regRead) begin
            case (regAddr)
                `SSE_REG_WORK: begin
                    next_state.readData = state.workReg;
                end
                `SSE_REG_STATUS: begin
                    next_state.readData[`SSE_BIT_CARRY]     = state.carry;
                    next_state.readData[`SSE_BIT_HALFCARRY] = state.halfCarry;
                    next_state.readData[`SSE_BIT_ZERO]      = state.zero;
                    next_state.readData[`SSE_BIT_POWERDOWN] = state.powerdownFlag;
                    next_state.readData[`SSE_BIT_TIMEOUT]   = state.timeoutFlag;
                end
                `SSE_REG_DIR_A: begin
                    next_state.readData = state.dirA;
                end
                `SSE_REG_DIR_B: begin
                    next_state.readData = state.dirB;
                end
                `SSE_REG_DIR_C: begin
                    next_state.readData = state.dirC;
                end
                `SSE_REG_WATCHDOG: begin
                    next_state.readData = state.watchdog;
                end
                `SSE_REG_PRESCALE: begin
                    next_state.readData = state.prescale;
                end
                default: begin
                    next_state.readData = 8'h00;
                end
            endcase
        end

        // Register write; power flags are read only
        if (regWrite) begin
            case (regAddr)
                `SSE_REG_WORK: begin
                    next_state.workReg = regWriteData;
                end
                `SSE_REG_STATUS: begin
                    next_state.carry     = regWriteData[`SSE_BIT_CARRY];
                    next_state.halfCarry = regWriteData[`SSE_BIT_HALFCARRY];
                    next_state.zero      = regWriteData[`SSE_BIT_ZERO];
                end
                `SSE_REG_DIR_A: begin
                    next_state.dirA = regWriteData;
                end
                `SSE_REG_DIR_B: begin
                    next_state.dirB = regWriteData;
                end
                `SSE_REG_DIR_C: begin
                    next_state.dirC = regWriteData;
                end
                default: begin
                    next_state.readData = next_state.readData;
                end
            endcase
        end

        // Instruction execution overrides a same-cycle register write
        if (accepted) begin
            case (opcode)
                sse_pkg::SSE_HALT_OP: begin
                    next_state.powerdownFlag = 1'b0;
                    next_state.timeoutFlag   = 1'b1;
                    next_state.watchdog      = `SSE_WATCHDOG_CLEAR;
                    next_state.prescale      = `SSE_PRESCALE_CLEAR;
                    next_state.power         = sse_pkg::SSE_SLEEP;
                end
                sse_pkg::SSE_SUBTRACT_W_FROM_FILE_OP,
                sse_pkg::SSE_SUBTRACT_WITH_BORROW_OP: begin
                    next_state.carry     = subSum[8];
                    next_state.halfCarry = nibSum[4];
                    next_state.zero      = (subResult == 8'h00);
                    if (destSel) begin
                        next_state.fileWrite  = 1'b1;
                        next_state.fileWrAddr = fileAddr;
                        next_state.fileWrData = subResult;
                    end else begin
                        next_state.workReg = subResult;
                    end
                end
                sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP: begin
                    next_state.carry     = subSum[8];
                    next_state.halfCarry = nibSum[4];
                    next_state.zero      = (subResult == 8'h00);
                    next_state.workReg   = subResult;
                end
                sse_pkg::SSE_NIBBLE_EXCHANGE_OP: begin
                    if (destSel) begin
                        next_state.fileWrite  = 1'b1;
                        next_state.fileWrAddr = fileAddr;
                        next_state.fileWrData = swapped;
                    end else begin
                        next_state.workReg = swapped;
                    end
                end
                sse_pkg::SSE_DIRECTION_LOAD_OP: begin
                    case (fileAddr)
                        `SSE_DIR_SEL_A: begin
                            next_state.dirA = state.workReg;
                        end
                        `SSE_DIR_SEL_B: begin
                            next_state.dirB = state.workReg;
                        end
                        `SSE_DIR_SEL_C: begin
                            next_state.dirC = state.workReg;
                        end
                        default: begin
                            next_state.dirA = state.dirA;
                        end
                    endcase
                end
                default: begin
                    next_state.power = state.power;
                end
            endcase
        end else if ((state.power == sse_pkg::SSE_SLEEP) && wakeRequest) begin
            // Wake restarts the oscillator, flags kept
            next_state.power = sse_pkg::SSE_RUN;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= RESET_STATE;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

    // Output mapping
    assign execReady           = (state.power == sse_pkg::SSE_RUN);
    assign sleepState          = (state.power == sse_pkg::SSE_SLEEP);
    assign oscillatorRun       = (state.power == sse_pkg::SSE_RUN);
    assign fileWriteStrobe     = state.fileWrite;
    assign fileWriteAddr       = state.fileWrAddr;
    assign fileWriteData       = state.fileWrData;
    assign timeoutStatusFlag   = state.timeoutFlag;
    assign powerdownStatusFlag = state.powerdownFlag;
    assign workReg             = state.workReg;
    assign carryFlag           = state.carry;
    assign halfCarryFlag       = state.halfCarry;
    assign zeroFlag            = state.zero;
    assign watchdogCounter     = state.watchdog;
    assign portADirection      = state.dirA;
    assign portBDirection      = state.dirB;
    assign portCDirection      = state.dirC;
    assign regReadData         = state.readData;

    // ****************************************
    // Checks
    // ****************************************
    logic takeNow;
    assign takeNow = clockEnable && accepted;

    // Halt flags
    halt_flags_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_HALT_OP
        |=> !powerdownStatusFlag && timeoutStatusFlag)
        else $error("halt did not update power flags");

    // Halt watchdog clear
    watchdog_clear_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_HALT_OP
        |=> watchdogCounter == 8'h00 && state.prescale == 8'h00)
        else $error("halt did not clear watchdog");

    // Halt enters sleep on the next cycle, oscillator stopped and not ready
    sleep_entry_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_HALT_OP
        |=> sleepState && !oscillatorRun && !execReady)
        else $error("halt did not enter sleep");

    // Subtract from file
    sub_file_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_SUBTRACT_W_FROM_FILE_OP
        |=> ($past(destSel)
            ? (fileWriteStrobe && fileWriteAddr == $past(fileAddr)
               && fileWriteData == 8'($past(fileData) - $past(workReg)))
            : (!fileWriteStrobe && workReg == 8'($past(fileData) - $past(workReg)))))
        else $error("subtract from file result wrong");

    // Subtract with borrow
    sub_borrow_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_SUBTRACT_WITH_BORROW_OP && !destSel
        |=> workReg == 8'($past(fileData) - $past(workReg) - {7'h00, !$past(carryFlag)}))
        else $error("subtract with borrow result wrong");

    // Subtract with borrow to file
    borrow_dest_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_SUBTRACT_WITH_BORROW_OP && destSel
        |=> fileWriteStrobe && $stable(workReg))
        else $error("subtract with borrow destination wrong");

    // Subtract from literal
    sub_literal_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP
        |=> !fileWriteStrobe && workReg == 8'($past(literal) - $past(workReg)))
        else $error("subtract from literal result wrong");

    // Carry and zero after subtract from file
    sub_flags_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_SUBTRACT_W_FROM_FILE_OP
        |=> carryFlag == ($past(workReg) <= $past(fileData))
            && halfCarryFlag == ($past(workReg[3:0]) <= $past(fileData[3:0]))
            && zeroFlag == ($past(workReg) == $past(fileData)))
        else $error("subtract flags wrong");

    // Nibble exchange keeps flags
    swap_flags_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_NIBBLE_EXCHANGE_OP && !regWrite
        |=> $stable(carryFlag) && $stable(halfCarryFlag) && $stable(zeroFlag))
        else $error("nibble exchange changed flags");

    // Nibble exchange destination
    swap_dest_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_NIBBLE_EXCHANGE_OP && destSel
        |=> fileWriteStrobe && fileWriteData == {$past(fileData[3:0]), $past(fileData[7:4])})
        else $error("nibble exchange result wrong");

    // Direction load to port B
    dir_load_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_DIRECTION_LOAD_OP && fileAddr == `SSE_DIR_SEL_B
        |=> portBDirection == $past(workReg) && $stable(portADirection))
        else $error("direction load wrong");

    // Bad selector holds directions
    dir_hold_a: assert property (@(posedge clock) disable iff (rst)
        takeNow && opcode == sse_pkg::SSE_DIRECTION_LOAD_OP && !regWrite
        && (fileAddr < `SSE_DIR_SEL_A || fileAddr > `SSE_DIR_SEL_C)
        |=> $stable(portADirection) && $stable(portBDirection) && $stable(portCDirection))
        else $error("bad selector changed directions");

endmodule

`default_nettype wire

// [rtl/sse_defs.svh]
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// ****************************************
// Register map of the control port
// ****************************************
`define SSE_ADDR_WIDTH   3
`define SSE_REG_WORK     3'h0
`define SSE_REG_STATUS   3'h1
`define SSE_REG_DIR_A    3'h2
`define SSE_REG_DIR_B    3'h3
`define SSE_REG_DIR_C    3'h4
`define SSE_REG_WATCHDOG 3'h5
`define SSE_REG_PRESCALE 3'h6

// ****************************************
// Status register bit positions
// ****************************************
`define SSE_BIT_CARRY     0
`define SSE_BIT_HALFCARRY 1
`define SSE_BIT_ZERO      2
`define SSE_BIT_POWERDOWN 3
`define SSE_BIT_TIMEOUT   4

// ****************************************
// Direction-load selectors
// ****************************************
`define SSE_DIR_SEL_A 7'h05
`define SSE_DIR_SEL_B 7'h06
`define SSE_DIR_SEL_C 7'h07

// ****************************************
// Reset and clear values
// ****************************************
`define SSE_DIR_RESET      8'hFF
`define SSE_WORK_RESET     8'h00
`define SSE_WATCHDOG_CLEAR 8'h00
`define SSE_PRESCALE_CLEAR 8'h00

`endif

// [rtl/sse_pkg.sv]
// ****************************************
// Shared types of the execution slice
// ****************************************
package sse_pkg;

    // Decoded instruction selector
    typedef enum logic [2:0] {
        SSE_NO_OP                     = 3'b000,
        SSE_SUBTRACT_W_FROM_FILE_OP   = 3'b001,
        SSE_SUBTRACT_WITH_BORROW_OP   = 3'b010,
        SSE_SUBTRACT_FROM_LITERAL_OP  = 3'b011,
        SSE_NIBBLE_EXCHANGE_OP        = 3'b100,
        SSE_DIRECTION_LOAD_OP         = 3'b101,
        SSE_HALT_OP                   = 3'b110
    } sse_op_type;

    // Power state of the core
    typedef enum logic {
        SSE_RUN   = 1'b0,
        SSE_SLEEP = 1'b1
    } sse_power_type;

    // Complete state of the slice
    typedef struct packed {
        logic [7:0]    workReg;
        logic          carry;
        logic          halfCarry;
        logic          zero;
        logic          powerdownFlag;
        logic          timeoutFlag;
        sse_power_type power;
        logic [7:0]    watchdog;
        logic [7:0]    prescale;
        logic [7:0]    dirA;
        logic [7:0]    dirB;
        logic [7:0]    dirC;
        logic          fileWrite;
        logic [6:0]    fileWrAddr;
        logic [7:0]    fileWrData;
        logic [7:0]    readData;
    } sse_state_type;

endpackage

// [sim/tb_cpu_subtract_swap_sleep_exec.sv]
`include "sse_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_cpu_subtract_swap_sleep_exec;
    // ****************************************
    // Stimulus, observation and counters
    // ****************************************
    logic                     clock, rst, clockEnable, execValid, destSel, wakeRequest;
    logic                     regWrite, regRead, execReady, fileWriteStrobe, sleepState;
    logic                     oscillatorRun, timeoutStatusFlag, powerdownStatusFlag;
    logic                     carryFlag, halfCarryFlag, zeroFlag;
    sse_pkg::sse_op_type      opcode;
    logic [6:0]               fileAddr, fileWriteAddr;
    logic [`SSE_ADDR_WIDTH-1:0] regAddr;
    logic [7:0]               literal, fileData, fileWriteData, workReg, watchdogCounter;
    logic [7:0]               portADirection, portBDirection, portCDirection;
    logic [7:0]               regWriteData, regReadData, w, f, lastRd;
    logic [10:0]              ef;
    logic [7:0]               eDir [3];
    logic                     c, d;
    int                       nMismatch, checked, seed;

    sse_exec i_dut (.clock(clock), .rst(rst), .clockEnable(clockEnable),
        .execValid(execValid), .opcode(opcode), .fileAddr(fileAddr), .destSel(destSel),
        .literal(literal), .fileData(fileData), .execReady(execReady),
        .fileWriteStrobe(fileWriteStrobe), .fileWriteAddr(fileWriteAddr),
        .fileWriteData(fileWriteData), .wakeRequest(wakeRequest), .sleepState(sleepState),
        .oscillatorRun(oscillatorRun), .timeoutStatusFlag(timeoutStatusFlag),
        .powerdownStatusFlag(powerdownStatusFlag), .workReg(workReg), .carryFlag(carryFlag),
        .halfCarryFlag(halfCarryFlag), .zeroFlag(zeroFlag), .watchdogCounter(watchdogCounter),
        .portADirection(portADirection), .portBDirection(portBDirection),
        .portCDirection(portCDirection), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));

    // ****************************************
    // Expectation and compare helpers
    // ****************************************
    // Returns carry, half carry, zero and the difference
    function automatic logic [10:0] subModel(input logic [7:0] a, input logic [7:0] b,
                                             input logic bin);
        logic [8:0] t;
        logic [4:0] l;
        t = {1'b0, a} - {1'b0, b} - 9'(bin);
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
        return {~t[8], ~l[4], t[7:0] == 8'h00, t[7:0]};
    endfunction

    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Flags against the last modelled subtract
    task automatic chkFlags();
        chkFlag(carryFlag, ef[10], "carry");
        chkFlag(halfCarryFlag, ef[9], "half carry");
        chkFlag(zeroFlag, ef[8], "zero");
    endtask

    // ****************************************
    // Bus drivers
    // ****************************************
    task automatic issue(input sse_pkg::sse_op_type op, input logic [6:0] a, input logic dd,
                         input logic [7:0] k, input logic [7:0] fv);
        @(posedge clock);
        execValid <= 1'b1;
        opcode    <= op;
        fileAddr  <= a;
        destSel   <= dd;
        literal   <= k;
        fileData  <= fv;
        @(posedge clock);
        execValid <= 1'b0;
        #1;
    endtask

    task automatic regWr(input logic [`SSE_ADDR_WIDTH-1:0] a, input logic [7:0] v);
        @(posedge clock);
        regWrite     <= 1'b1;
        regAddr      <= a;
        regWriteData <= v;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic regRd(input logic [`SSE_ADDR_WIDTH-1:0] a);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        lastRd = regReadData;
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d comparisons, %0d mismatches", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #20000;
        nMismatch++;
        $display("[FAIL] %0t run did not finish in time", $time);
        tally_and_finish();
    end

    initial begin
        seed = 32'hbe20;
        {rst, clockEnable, execValid, destSel, wakeRequest, regWrite, regRead} = 7'h60;
        opcode = sse_pkg::SSE_NO_OP;
        {fileAddr, literal, fileData, regAddr, regWriteData} = '0;
        eDir = '{8'hff, 8'hff, 8'hff};
        ef = 11'h000;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        regRd(`SSE_REG_STATUS);
        chkByte(lastRd, 8'h18, "status after reset");
        regWr(`SSE_REG_STATUS, 8'h00);
        regRd(`SSE_REG_STATUS);
        chkByte(lastRd, 8'h18, "status power bits read only");
        regRd(3'h7);
        chkByte(lastRd, 8'h00, "unmapped read");
        $display("test reset done");
        // Subtracts with corner operands first, then random ones
        for (int i = 0; i < 48; i++) begin
            w = (i < 6) ? 8'h00 + 8'(i * 8'h2f) : 8'($random(seed));
            f = (i < 6) ? 8'(i * 8'h11) + 8'(i[0]) : 8'($random(seed));
            c = 1'($random(seed));
            d = 1'($random(seed));
            regWr(`SSE_REG_WORK, w);
            regWr(`SSE_REG_STATUS, {7'h00, c});
            case (i % 3)
                0: ef = subModel(f, w, 1'b0);
                1: ef = subModel(f, w, ~c);
                default: ef = subModel(f, w, 1'b0);
            endcase
            issue(i % 3 == 0 ? sse_pkg::SSE_SUBTRACT_W_FROM_FILE_OP : i % 3 == 1
                ? sse_pkg::SSE_SUBTRACT_WITH_BORROW_OP : sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP,
                7'($random(seed)), d, f, i % 3 == 2 ? ~f : f);
            if (i % 3 == 2 || !d) begin
                chkByte(workReg, ef[7:0], "difference in W");
                chkFlag(fileWriteStrobe, 1'b0, "no file write");
            end else begin
                chkByte(fileWriteData, ef[7:0], "difference to file");
                chkFlag(fileWriteStrobe, 1'b1, "file write");
                chkByte({1'b0, fileWriteAddr}, {1'b0, fileAddr}, "file address");
                chkByte(workReg, w, "W kept");
            end
            chkFlags();
        end
        $display("test subtract done");
        // Nibble exchange to both destinations, flags untouched
        for (int i = 0; i < 2; i++) begin
            f = 8'($random(seed));
            issue(sse_pkg::SSE_NIBBLE_EXCHANGE_OP, 7'h21, i[0], 8'h00, f);
            chkByte(i[0] ? fileWriteData : workReg, {f[3:0], f[7:4]}, "swap");
            chkFlag(fileWriteStrobe, i[0], "swap write strobe");
            chkFlags();
        end
        $display("test swap done");
        // Direction loads: selectors 4 to 10, valid 5 to 7 between out-of-range ones
        foreach (eDir[j]) begin
            chkByte(j == 0 ? portADirection : j == 1 ? portBDirection : portCDirection,
                eDir[j], "direction before load");
        end
        for (int i = 0; i < 7; i++) begin
            f = 8'($random(seed));
            regWr(`SSE_REG_WORK, f);
            issue(sse_pkg::SSE_DIRECTION_LOAD_OP, 7'(i + 4), 1'b1, 8'h00, 8'h00);
            if (i >= 1 && i <= 3) begin
                eDir[i - 1] = f;
            end
            chkByte(portADirection, eDir[0], "direction A");
            chkByte(portBDirection, eDir[1], "direction B");
            chkByte(portCDirection, eDir[2], "direction C");
            chkFlags();
        end
        $display("test direction done");
        // Halt after the watchdog has advanced, then wake
        repeat (300) @(posedge clock);
        #1;
        chkFlag(watchdogCounter != 8'h00, 1'b1, "watchdog advanced");
        issue(sse_pkg::SSE_HALT_OP, 7'h00, 1'b0, 8'h00, 8'h00);
        chkFlag(powerdownStatusFlag, 1'b0, "power-down flag");
        chkFlag(timeoutStatusFlag, 1'b1, "time-out flag");
        chkByte(watchdogCounter, 8'h00, "watchdog cleared");
        chkFlag(sleepState, 1'b1, "asleep");
        chkFlag(oscillatorRun, 1'b0, "oscillator stopped");
        chkFlag(execReady, 1'b0, "not ready asleep");
        issue(sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP, 7'h00, 1'b0, 8'h77, 8'h00);
        chkByte(workReg, f, "ignored while asleep");
        regRd(`SSE_REG_STATUS);
        chkByte(lastRd, {3'b000, 1'b1, 1'b0, ef[8], ef[9], ef[10]}, "status asleep");
        @(posedge clock);
        wakeRequest <= 1'b1;
        @(posedge clock);
        wakeRequest <= 1'b0;
        #1;
        chkFlag(sleepState, 1'b0, "awake");
        chkFlag(powerdownStatusFlag, 1'b0, "power-down kept");
        // Clock enable low freezes an instruction
        clockEnable <= 1'b0;
        issue(sse_pkg::SSE_SUBTRACT_FROM_LITERAL_OP, 7'h00, 1'b0, 8'h77, 8'h00);
        chkByte(workReg, f, "frozen while disabled");
        clockEnable <= 1'b1;
        $display("test halt done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
